//--- socket_mode_defines.svh
/*
  Constants for the per-socket mode register bank: addresses, field
  positions, reset value and the SPI frame layout.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SOCKET_MODE_DEFINES_SVH
`define SOCKET_MODE_DEFINES_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define MODE_BASE 16'h4000
`define MODE_STRIDE 16'h0100
`define MODE_SOCK_MASK 16'h0700
`define MODE_SOCK_LSB 8
`define MODE_RESET 8'h00
`define NUM_SOCKETS 8

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MULTICAST_BIT 7
`define FILTER_BIT 6
`define ACK_IGMP_BIT 5
`define RESERVED_BIT 4
`define PROTO_MSB 3
`define IGMP_V1 2'h1
`define IGMP_V2 2'h2
`define IGMP_NONE 2'h0

// ----------------------------------------
// SPI frame
// ----------------------------------------
`define OP_WRITE_BIT 7
`define LAST_BIT 3'h7
`endif

//--- socket_mode_pkg.sv
/*
  Types shared by the mode register bank and its socket slots.
  Assumes socket_mode_defines.svh is available for the constants.
*/
package socket_mode_pkg;
  typedef enum logic [3:0] {
    PROTO_CLOSED = 4'h0,
    PROTO_TCP = 4'h1,
    PROTO_UDP = 4'h2,
    PROTO_RAW_IP = 4'h3,
    PROTO_RAW_FRAME = 4'h4,
    PROTO_PPPOE = 4'h5
  } proto_type;

  typedef enum logic [7:0] {
    ST_CLOSED = 8'h00,
    ST_TCP_READY = 8'h13,
    ST_UDP = 8'h22,
    ST_RAW_IP = 8'h32,
    ST_RAW_FRAME = 8'h42,
    ST_PPPOE = 8'h5F
  } socket_state_type;

  typedef enum logic [2:0] {
    PH_ADDR_HI = 3'h0,
    PH_ADDR_LO = 3'h1,
    PH_OP_HI = 3'h3,
    PH_OP_LO = 3'h2,
    PH_DATA = 3'h6
  } spi_phase_type;
endpackage

//--- socket_mode_slot.sv
/*
  One socket: its mode register and the settings captured at open.
  Assumes write, open and close pulses come from the ref_clk domain.
*/
`timescale 1ns/100ps
`include "socket_mode_defines.svh"
module socket_mode_slot #(
  parameter logic [2:0] SOCK_INDEX = 3'h0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic open_cmd,
  input wire logic close_cmd,
  output logic [7:0] mode_q,
  output socket_mode_pkg::socket_state_type state_q,
  output socket_mode_pkg::proto_type protocol_q,
  output logic multicast_q,
  output logic filter_q,
  output logic accept_all_q,
  output logic immediate_ack_q,
  output logic delayed_ack_q,
  output logic [1:0] igmp_version_q
);
  import socket_mode_pkg::*;

  proto_type proto_d;
  socket_state_type state_d;
  logic multi_bit;
  logic opt_bit;

  assign multi_bit = mode_q[`MULTICAST_BIT];
  assign opt_bit = mode_q[`ACK_IGMP_BIT];

  // Reserved bit is stored for read-back only
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      mode_q <= `MODE_RESET;
    else if (wr_en)
      mode_q <= wr_data;

  always_comb
  begin
    proto_d = PROTO_CLOSED;
    state_d = ST_CLOSED;
    case (mode_q[`PROTO_MSB:0])
      4'h1:
      begin
        proto_d = PROTO_TCP;
        state_d = ST_TCP_READY;
      end
      4'h2:
      begin
        proto_d = PROTO_UDP;
        state_d = ST_UDP;
      end
      4'h3:
      begin
        proto_d = PROTO_RAW_IP;
        state_d = ST_RAW_IP;
      end
      // Other sockets fall back to closed
      4'h4:
        if (SOCK_INDEX == 3'h0)
        begin
          proto_d = PROTO_RAW_FRAME;
          state_d = ST_RAW_FRAME;
        end
      4'h5:
        if (SOCK_INDEX == 3'h0)
        begin
          proto_d = PROTO_PPPOE;
          state_d = ST_PPPOE;
        end
      default:
      begin
        proto_d = PROTO_CLOSED;
        state_d = ST_CLOSED;
      end
    endcase
  end

  // Settings only move on open or close
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      state_q <= ST_CLOSED;
      protocol_q <= PROTO_CLOSED;
      multicast_q <= 1'b0;
      filter_q <= 1'b0;
      accept_all_q <= 1'b0;
      immediate_ack_q <= 1'b0;
      delayed_ack_q <= 1'b0;
      igmp_version_q <= `IGMP_NONE;
    end
    else if (close_cmd)
    begin
      state_q <= ST_CLOSED;
      protocol_q <= PROTO_CLOSED;
      multicast_q <= 1'b0;
      filter_q <= 1'b0;
      accept_all_q <= 1'b0;
      immediate_ack_q <= 1'b0;
      delayed_ack_q <= 1'b0;
      igmp_version_q <= `IGMP_NONE;
    end
    else if (open_cmd)
    begin
      state_q <= state_d;
      protocol_q <= proto_d;
      multicast_q <= (proto_d == PROTO_UDP) && multi_bit;
      filter_q <= (proto_d == PROTO_RAW_FRAME) && mode_q[`FILTER_BIT];
      accept_all_q <= (proto_d == PROTO_RAW_FRAME) &&
        !mode_q[`FILTER_BIT];
      immediate_ack_q <= (proto_d == PROTO_TCP) && opt_bit;
      delayed_ack_q <= (proto_d == PROTO_TCP) && !opt_bit;
      // Version feeds join, leave and report messages
      if ((proto_d == PROTO_UDP) && multi_bit)
        igmp_version_q <= opt_bit ? `IGMP_V1 : `IGMP_V2;
      else
        igmp_version_q <= `IGMP_NONE;
    end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_tcp_state;
    open_cmd && !close_cmd && mode_q[3:0] == 4'h1 |=>
      state_q == ST_TCP_READY && protocol_q == PROTO_TCP;
  endproperty
  a_tcp_state: assert property (p_tcp_state)
    else $error("tcp open did not reach ready state");

  property p_udp_state;
    open_cmd && !close_cmd && mode_q[3:0] == 4'h2 |=> state_q == ST_UDP;
  endproperty
  a_udp_state: assert property (p_udp_state)
    else $error("udp open gave wrong state");

  property p_hold;
    !open_cmd && !close_cmd |=> $stable(state_q) && $stable(igmp_version_q)
      && $stable(multicast_q) && $stable(immediate_ack_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("settings changed without open or close");

  property p_multicast;
    multicast_q |-> protocol_q == PROTO_UDP;
  endproperty
  a_multicast: assert property (p_multicast)
    else $error("multicast active outside udp");

  property p_igmp;
    open_cmd && !close_cmd && mode_q[3:0] == 4'h2 && multi_bit && !opt_bit
      |=> igmp_version_q == `IGMP_V2;
  endproperty
  a_igmp: assert property (p_igmp)
    else $error("igmp version two not selected");

  property p_ack;
    immediate_ack_q |-> protocol_q == PROTO_TCP && !delayed_ack_q;
  endproperty
  a_ack: assert property (p_ack)
    else $error("immediate ack outside tcp");

  property p_raw_only0;
    protocol_q == PROTO_RAW_FRAME || protocol_q == PROTO_PPPOE |->
      SOCK_INDEX == 3'h0;
  endproperty
  a_raw_only0: assert property (p_raw_only0)
    else $error("raw frame mode on a non-zero socket");

  property p_filter;
    $rose(filter_q) |-> !accept_all_q && $past(open_cmd);
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter set without open");

  c_tcp_open: cover property (open_cmd ##1 state_q == ST_TCP_READY);
  c_multicast: cover property (open_cmd ##1 multicast_q);
endmodule

//--- socket_mode_config.sv
/*
  Mode register bank for eight sockets, reached over SPI mode 0.
  Assumes sclk runs at most ref_clk/8, and open/close pulses come
  from command logic on ref_clk.
*/
`timescale 1ns/100ps
`include "socket_mode_defines.svh"
module socket_mode_config (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic scs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [7:0] open_cmd,
  input wire logic [7:0] close_cmd,
  output socket_mode_pkg::socket_state_type socket_state [8],
  output socket_mode_pkg::proto_type protocol_select [8],
  output logic [7:0] multicast_en,
  output logic [7:0] frame_address_filter,
  output logic [7:0] accept_all_frames,
  output logic [7:0] immediate_ack,
  output logic [7:0] delayed_ack,
  output logic [1:0] igmp_version [8]
);
  import socket_mode_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;
  logic cs_s1_q;
  logic cs_s2_q;
  logic mosi_s1_q;
  logic mosi_s2_q;

  // Oversampled link: each sclk level must last four clocks or more
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end
    else
    begin
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= scs_n;
      cs_s2_q <= cs_s1_q;
      mosi_s1_q <= mosi;
      mosi_s2_q <= mosi_s1_q;
    end

  logic selected;
  logic sclk_rise;
  logic sclk_fall;

  // Edge detect uses the second and third stages only
  assign selected = !cs_s2_q;
  assign sclk_rise = selected && sclk_s2_q && !sclk_s3_q;
  assign sclk_fall = selected && !sclk_s2_q && sclk_s3_q;

  // ----------------------------------------
  // Byte assembly
  // ----------------------------------------
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic byte_done;
  logic [7:0] rx_byte;

  assign byte_done = sclk_rise && (bit_cnt_q == `LAST_BIT);
  assign rx_byte = {shift_q, mosi_s2_q};

  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end
    else if (!selected)
      bit_cnt_q <= 3'h0;
    else if (sclk_rise)
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= rx_byte[6:0];
    end

  // ----------------------------------------
  // Frame sequencing
  // ----------------------------------------
  spi_phase_type phase_q;
  logic [15:0] addr_q;
  logic write_q;
  logic [14:0] len_q;

  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      phase_q <= PH_ADDR_HI;
    else if (!selected)
      phase_q <= PH_ADDR_HI;
    else if (byte_done)
      case (phase_q)
        PH_ADDR_HI: phase_q <= PH_ADDR_LO;
        PH_ADDR_LO: phase_q <= PH_OP_HI;
        PH_OP_HI: phase_q <= PH_OP_LO;
        PH_OP_LO: phase_q <= PH_DATA;
        default: phase_q <= PH_DATA;
      endcase

  logic data_byte;

  // Bytes beyond the stated length are ignored
  assign data_byte = byte_done && (phase_q == PH_DATA) && (len_q != 15'h0000);

  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      addr_q <= 16'h0000;
    else if (byte_done && phase_q == PH_ADDR_HI)
      addr_q[15:8] <= rx_byte;
    else if (byte_done && phase_q == PH_ADDR_LO)
      addr_q[7:0] <= rx_byte;
    else if (data_byte)
      addr_q <= addr_q + 16'h0001;

  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      write_q <= 1'b0;
      len_q <= 15'h0000;
    end
    else if (byte_done && phase_q == PH_OP_HI)
    begin
      write_q <= rx_byte[`OP_WRITE_BIT];
      len_q[14:8] <= rx_byte[6:0];
    end
    else if (byte_done && phase_q == PH_OP_LO)
      len_q[7:0] <= rx_byte;
    else if (data_byte)
      len_q <= len_q - 15'h0001;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [7:0] mode_rd [8];

  function automatic logic [7:0] read_at(input logic [15:0] a);
    logic [7:0] r;
    r = 8'h00;
    if ((a & ~`MODE_SOCK_MASK) == `MODE_BASE)
      r = mode_rd[a[`MODE_SOCK_LSB +: 3]];
    else
      r = 8'h00;
    return r;
  endfunction

  logic addr_hit;

  assign addr_hit = (addr_q & ~`MODE_SOCK_MASK) == `MODE_BASE;

  // Write is issued one cycle after the byte lands
  logic wr_q;
  logic [2:0] wr_sock_q;
  logic [7:0] wr_data_q;

  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      wr_q <= 1'b0;
      wr_sock_q <= 3'h0;
      wr_data_q <= 8'h00;
    end
    else
    begin
      wr_q <= data_byte && write_q && addr_hit;
      wr_sock_q <= addr_q[`MODE_SOCK_LSB +: 3];
      wr_data_q <= rx_byte;
    end

  // ----------------------------------------
  // Read data out
  // ----------------------------------------
  logic [7:0] tx_q;
  logic miso_q;
  logic miso_oe_q;

  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end
    else if (!selected)
    begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end
    else if (byte_done && phase_q == PH_OP_LO && !write_q)
      tx_q <= read_at(addr_q);
    else if (data_byte && !write_q)
      tx_q <= read_at(addr_q + 16'h0001);
    else if (sclk_fall)
    begin
      miso_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end

  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      miso_oe_q <= 1'b0;
    else
      miso_oe_q <= selected;

  assign miso = miso_q;
  assign miso_oe = miso_oe_q;

  // ----------------------------------------
  // Socket slots
  // ----------------------------------------
  logic [7:0] slot_wr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  for (genvar k = 0; k < `NUM_SOCKETS; k++)
  begin : g_slot
    assign slot_wr[k] = wr_q && (wr_sock_q == 3'(k));

    socket_mode_slot #(
      .SOCK_INDEX(3'(k))
    ) u_slot (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .wr_en(slot_wr[k]),
      .wr_data(wr_data_q),
      .open_cmd(open_cmd[k]),
      .close_cmd(close_cmd[k]),
      .mode_q(mode_rd[k]),
      .state_q(socket_state[k]),
      .protocol_q(protocol_select[k]),
      .multicast_q(multicast_en[k]),
      .filter_q(frame_address_filter[k]),
      .accept_all_q(accept_all_frames[k]),
      .immediate_ack_q(immediate_ack[k]),
      .delayed_ack_q(delayed_ack[k]),
      .igmp_version_q(igmp_version[k])
    );

    property p_write;
      slot_wr[k] |=> mode_rd[k] == $past(wr_data_q);
    endproperty
    a_write: assert property (p_write)
      else $error("mode register write lost");
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_one_slot;
    $onehot0(slot_wr) && (wr_q == (slot_wr != 8'h00));
  endproperty
  a_one_slot: assert property (p_one_slot)
    else $error("write reached more or fewer than one socket");

  // Socket and byte are taken from the write cycle, not the cycle after
  property p_write_path;
    data_byte && write_q && addr_hit |=> wr_q ##1
      mode_rd[$past(wr_sock_q)] == $past(wr_data_q);
  endproperty
  a_write_path: assert property (p_write_path)
    else $error("decoded write not applied");

  property p_unmapped;
    data_byte && write_q && !addr_hit |=> !wr_q;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("write outside the mode registers reached a socket");

  property p_len_stop;
    byte_done && phase_q == PH_DATA && len_q == 15'h0000 |=> !wr_q;
  endproperty
  a_len_stop: assert property (p_len_stop)
    else $error("byte beyond the stated length was written");

  property p_oe;
    miso_oe == $past(selected);
  endproperty
  a_oe: assert property (p_oe)
    else $error("data out enable does not follow chip select");

  c_spi_write: cover property (wr_q);
  c_spi_read: cover property (data_byte && !write_q && addr_hit);
endmodule

//--- spi_host_model.sv
/*
  Behavioural SPI host for the mode register bank, mode 0 frames.
  Assumes ref_clk is the device clock; sclk timing is counted from it.
*/
`timescale 1ns/100ps
module spi_host_model (
  input wire logic ref_clk,
  output logic sclk,
  output logic scs_n,
  output logic mosi,
  input wire logic miso
);
  // Half sclk period in ref_clk cycles; device needs at least 4
  localparam int HALF = 6;

  initial
  begin
    sclk = 1'b0;
    scs_n = 1'b1;
    mosi = 1'b0;
  end

  // Deselected data line toggles so stale bits never look valid
  always @(negedge ref_clk)
    if (scs_n)
      mosi <= ~mosi;

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      tick(HALF);
      rx[i] = miso;
      sclk = 1'b1;
      tick(HALF);
      sclk = 1'b0;
    end
  endtask

  // ----------------------------------------
  // One-byte frame: address, op with length 1, data
  // ----------------------------------------
  task automatic frame(input logic [15:0] addr, input logic wr,
                       input logic [7:0] wdata, output logic [7:0] rdata);
    logic [7:0] junk;
    scs_n = 1'b0;
    tick(HALF);
    shift_byte(addr[15:8], junk);
    shift_byte(addr[7:0], junk);
    shift_byte({wr, 7'h00}, junk);
    shift_byte(8'h01, junk);
    shift_byte(wdata, rdata);
    tick(HALF);
    scs_n = 1'b1;
    tick(4 * HALF);
  endtask
endmodule

//--- test_socket_mode_config.sv
/*
  Self-checking bench for socket_mode_config: register access over SPI,
  socket open and close, and the options captured at open.
  Assumes spi_host_model and the design files are compiled first.
*/
`timescale 1ns/100ps
module test_socket_mode_config;
  import socket_mode_pkg::*;
  logic ref_clk;
  logic arst_n;
  logic sclk;
  logic scs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic [7:0] open_cmd;
  logic [7:0] close_cmd;
  socket_state_type socket_state [8];
  proto_type protocol_select [8];
  logic [7:0] multicast_en;
  logic [7:0] frame_address_filter;
  logic [7:0] accept_all_frames;
  logic [7:0] immediate_ack;
  logic [7:0] delayed_ack;
  logic [1:0] igmp_version [8];
  int n_errors;
  int tests_run;
  localparam int NT = 11;
  // Flags: multicast, filter, accept all, immediate, delayed, igmp
  logic [7:0] t_mode [NT] = '{8'h00, 8'h21, 8'h01, 8'h82, 8'hA2, 8'h22,
    8'h83, 8'h44, 8'h04, 8'h05, 8'h06};
  socket_state_type t_st [NT] = '{ST_CLOSED, ST_TCP_READY, ST_TCP_READY,
    ST_UDP, ST_UDP, ST_UDP, ST_RAW_IP, ST_RAW_FRAME, ST_RAW_FRAME,
    ST_PPPOE, ST_CLOSED};
  logic [6:0] t_fl [NT] = '{7'h00, 7'h08, 7'h04, 7'h42, 7'h41, 7'h00,
    7'h00, 7'h20, 7'h10, 7'h00, 7'h00};

  socket_mode_config u_socket_mode_config (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sclk(sclk),
    .scs_n(scs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .open_cmd(open_cmd),
    .close_cmd(close_cmd),
    .socket_state(socket_state),
    .protocol_select(protocol_select),
    .multicast_en(multicast_en),
    .frame_address_filter(frame_address_filter),
    .accept_all_frames(accept_all_frames),
    .immediate_ack(immediate_ack),
    .delayed_ack(delayed_ack),
    .igmp_version(igmp_version)
  );

  spi_host_model u_spi_host_model (
    .ref_clk(ref_clk),
    .sclk(sclk),
    .scs_n(scs_n),
    .mosi(mosi),
    .miso(miso)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_slot(input int k, input socket_state_type st,
                            input logic [6:0] flags);
    logic [6:0] got;
    proto_type pe;
    got = {multicast_en[k], frame_address_filter[k], accept_all_frames[k],
           immediate_ack[k], delayed_ack[k], igmp_version[k]};
    case (st)
      ST_TCP_READY: pe = PROTO_TCP;
      ST_UDP: pe = PROTO_UDP;
      ST_RAW_IP: pe = PROTO_RAW_IP;
      ST_RAW_FRAME: pe = PROTO_RAW_FRAME;
      ST_PPPOE: pe = PROTO_PPPOE;
      default: pe = PROTO_CLOSED;
    endcase
    tests_run++;
    if (socket_state[k] !== st || got !== flags ||
        protocol_select[k] !== pe)
    begin
      n_errors++;
      $display("BAD %0t socket %0d state %h proto %h flags %b", $time, k,
               socket_state[k], protocol_select[k], got);
    end
  endtask

  function automatic logic [15:0] sock_addr(input int k);
    return 16'h4000 + 16'(k) * 16'h0100;
  endfunction

  task automatic reg_write(input logic [15:0] addr, input logic [7:0] v);
    logic [7:0] junk;
    u_spi_host_model.frame(addr, 1'b1, v, junk);
  endtask

  task automatic reg_read(input logic [15:0] addr, input logic [7:0] exp,
                          input string what);
    logic [7:0] got;
    u_spi_host_model.frame(addr, 1'b0, 8'h00, got);
    check_byte(got, exp, what);
  endtask

  task automatic pulse(input logic [7:0] op, input logic [7:0] cl);
    open_cmd = op;
    close_cmd = cl;
    @(negedge ref_clk);
    open_cmd = 8'h00;
    close_cmd = 8'h00;
    repeat (2) @(negedge ref_clk);
  endtask

  // Guard against a hung run
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    $display("BAD %0t run did not finish", $time);
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    arst_n = 1'b0;
    open_cmd = 8'h00;
    close_cmd = 8'h00;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check_byte({7'h00, miso_oe}, 8'h00, "miso_oe after reset");
    for (int k = 0; k < 8; k++)
    begin
      check_slot(k, ST_CLOSED, 7'h00);
      reg_read(sock_addr(k), 8'h00, "reset value");
    end
    $display("test reset done");
    // Distinct values catch aliasing between sockets; bit 4 included
    for (int k = 0; k < 8; k++)
      reg_write(sock_addr(k), 8'h10 + 8'(k) * 8'h21);
    for (int k = 0; k < 8; k++)
      reg_read(sock_addr(k), 8'h10 + 8'(k) * 8'h21, "readback");
    reg_write(16'h4001, 8'hFF);
    reg_read(16'h4001, 8'h00, "unmapped");
    reg_read(sock_addr(0), 8'h10, "neighbour");
    $display("test access done");
    // Filter bit set in raw frame entry, as a hybrid stack host would
    for (int i = 0; i < NT; i++)
    begin
      reg_write(sock_addr(0), t_mode[i]);
      pulse(8'h01, 8'h00);
      check_slot(0, t_st[i], t_fl[i]);
    end
    for (int c = 4; c < 6; c++)
    begin
      reg_write(sock_addr(3), 8'(c));
      pulse(8'h08, 8'h00);
      check_slot(3, ST_CLOSED, 7'h00);
    end
    reg_write(sock_addr(7), 8'h82);
    pulse(8'h80, 8'h00);
    check_slot(7, ST_UDP, 7'h42);
    $display("test protocols done");
    reg_write(sock_addr(0), 8'h21);
    pulse(8'h01, 8'h00);
    reg_write(sock_addr(0), 8'h02);
    check_slot(0, ST_TCP_READY, 7'h08);
    reg_read(sock_addr(0), 8'h02, "stored while open");
    pulse(8'h00, 8'h01);
    check_slot(0, ST_CLOSED, 7'h00);
    pulse(8'h01, 8'h01);
    check_slot(0, ST_CLOSED, 7'h00);
    pulse(8'h01, 8'h00);
    check_slot(0, ST_UDP, 7'h00);
    // Enable is looked at early in the frame, during the first address byte
    fork
      reg_read(sock_addr(1), 8'h31, "read while enabled");
      begin
        repeat (20) @(negedge ref_clk);
        check_byte({7'h00, miso_oe}, 8'h01, "miso_oe in frame");
      end
    join
    check_byte({7'h00, miso_oe}, 8'h00, "miso_oe after frame");
    $display("test reopen done");
    end_of_test();
  end
endmodule
